// >>> src/ewc_defs.vh
// Constants for the external bus wait controller.
// Included by the controller; definitions only.
`ifndef EWC_DEFS_VH
`define EWC_DEFS_VH

// Register map: the wait control register sits at its printed byte address
`define EWC_WAIT_CTRL_ADDR 32'h00800180
// Own register: operating mode and bus strobe style
`define EWC_MODE_CTRL_ADDR 32'h00800184
`define EWC_WAIT_CTRL_RESET 8'h00
`define EWC_MODE_CTRL_RESET 8'h00
`define EWC_WAIT_CTRL_MASK 8'h33

// Field positions, MSB-first bit 0 maps to data bit 7 of the byte
`define EWC_AREA0_FIELD_HI 5
`define EWC_AREA0_FIELD_LO 4
`define EWC_AREA1_FIELD_HI 1
`define EWC_AREA1_FIELD_LO 0
`define EWC_MODE_FIELD_HI 1
`define EWC_MODE_FIELD_LO 0
`define EWC_STYLE_BIT 2

// Operating modes
`define EWC_MODE_SINGLE 2'h0
`define EWC_MODE_EXTEND 2'h1
`define EWC_MODE_PROC 2'h2

// Address decode, 1 Mbyte areas selected by address bits 23:20
`define EWC_AREA_NIBBLE_0 4'h0
`define EWC_AREA_NIBBLE_1 4'h1
`define EWC_AREA_NIBBLE_2 4'h2
`define EWC_AREA_NIBBLE_3 4'h3

// AXI responses
`define EWC_RESP_OKAY 2'h0
`define EWC_RESP_SLVERR 2'h2

`endif

// >>> src/ewc_wait_controller.v
// External bus wait controller: decode, wait counting, strobes, registers.
// Assumes a core-side access request held until accDone, synchronous pins,
// and an AXI4-Lite master on the same 25 MHz clock.
// Timing in brief: the select edge E opens a cycle, the last programmed
// wait samples the wait pin, and accDone pulses one edge after the wait
// ends, so an access without pin waits spans N+1 clocks from E.
// The register bus answers a write once both channels are held and a
// read at the same edge that takes its address; one of each at a time.
// Limitation: the wait pin is taken as already synchronous to clock,
// so a board with a slow or asynchronous wait source needs its own
// synchroniser in front of this block.
//
// Summary of operation
// - External accesses only happen in external extension or processor mode.
// - External bus bit 0 is MSB; memory wiring reverses significance.
// - Single-chip mode ignores wait settings; nothing is inserted.
// - Two 1 Mbyte areas exist, one per chip select.
// - Two active-low chip selects, each asserted only for its own area.
// - Each external access has 1 to 4 programmed waits plus pin-requested waits.
// - Shortest external cycle holds exactly one wait; never zero waits.
// - Wait pin sampled in last programmed wait; low prolongs the wait.
// - Wait pin back high ends the wait and the bus cycle proceeds.
// - Programmed waits complete first; the pin only adds after them.
// - Extension mode: area 0 at 0x00100000 to 0x001fffff.
// - Processor mode: area 0 at 0x00000000 to 0x000fffff.
// - Processor mode: area 0 mirrored at 0x00100000 to 0x001fffff.
// - Both expanded modes: area 1 at 0x00200000 to 0x002fffff.
// - Area 1 mirrored at 0x00300000 to 0x003fffff.
// - Area 0 field: 00 four, 01 three, 10 two, 11 one; resets 00.
// - Area 1 field: same encoding as area 0; resets 00.
// - Software waits alone give 2 to 5 cycle accesses.
// - Style 0: read and per-byte write strobes; 1: byte enables, write.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ewc_defs.vh"

module ewc_wait_controller (
   input wire clock,
   input wire rst_b,
   input wire clockEnable,
   // Core-side access request
   input wire accReq,
   input wire [31:0] accAddr,
   input wire accWrite,
   input wire [1:0] accByteEn,
   output reg accDone,
   output reg accExternal,
   // External bus pins, all strobes active low
   input wire wait_b,
   output reg area0_chip_select_b,
   output reg area1_chip_select_b,
   output reg read_strobe_b,
   output reg upper_byte_write_strobe_b,
   output reg lower_byte_write_strobe_b,
   output reg upper_byte_enable_b,
   output reg lower_byte_enable_b,
   output reg write_strobe_b,
   output reg busClockEnable,
   // AXI4-Lite slave
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // Sequencer states: idle, programmed waits, pin waits, closing edge.
   // The closing edge is its own state so every strobe rises together
   // with accDone and the far side sees one clean end of cycle.
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_EXTWAIT = 2'h2;
   localparam ST_END = 2'h3;

   // Software-visible registers
   reg [7:0] external_wait_cycles_control;
   reg [7:0] modeControl;

   // Sequencer state and its remaining programmed waits
   reg [1:0] state;
   reg [2:0] waitCount;

   // Write channels held until both halves of a write have arrived
   reg [31:0] awAddrHeld;
   reg awHeld;
   reg [31:0] wDataHeld;
   reg [3:0] wStrbHeld;
   reg wHeld;

   wire [1:0] opMode;
   wire strobeStyle;
   wire [3:0] areaNibble;
   wire [1:0] area0_wait_count_field;
   wire [1:0] area1_wait_count_field;
   reg hitArea0;
   reg hitArea1;
   reg [2:0] next_waitCount;
   wire anyHit;
   wire lastWait;

   // Pin levels for a new cycle, worked out ahead of the take edge
   reg next_readStrobe;
   reg next_upperWrite;
   reg next_lowerWrite;
   reg next_upperEnable;
   reg next_lowerEnable;
   reg next_commonWrite;
   reg next_busClock;

   // Register decode for both bus directions
   wire wrHitWait;
   wire wrHitMode;
   wire rdHitWait;
   wire rdHitMode;
   wire [7:0] wrWaitValue;
   wire [7:0] wrModeValue;
   reg [31:0] next_readData;
   reg next_readError;

   assign opMode = modeControl[`EWC_MODE_FIELD_HI:`EWC_MODE_FIELD_LO];
   assign strobeStyle = modeControl[`EWC_STYLE_BIT];
   assign areaNibble = accAddr[23:20];
   // Bit 0 of the bus is the MSB, so each field sits mirrored in the byte
   assign area0_wait_count_field = external_wait_cycles_control[
      `EWC_AREA0_FIELD_HI:`EWC_AREA0_FIELD_LO];
   assign area1_wait_count_field = external_wait_cycles_control[
      `EWC_AREA1_FIELD_HI:`EWC_AREA1_FIELD_LO];

   // Any area hit starts an external cycle; last wait samples the pin
   assign anyHit = hitArea0 || hitArea1;
   assign lastWait = (waitCount == 3'h1);

   // Register hits compare word addresses; the low two bits are ignored
   assign wrHitWait = (awAddrHeld[31:2] == `EWC_WAIT_CTRL_ADDR >> 2);
   assign wrHitMode = (awAddrHeld[31:2] == `EWC_MODE_CTRL_ADDR >> 2);
   assign rdHitWait = (s_axi_araddr[31:2] == `EWC_WAIT_CTRL_ADDR >> 2);
   assign rdHitMode = (s_axi_araddr[31:2] == `EWC_MODE_CTRL_ADDR >> 2);

   // Unassigned wait bits stay zero; fields only hold their own value
   assign wrWaitValue = wDataHeld[7:0] & `EWC_WAIT_CTRL_MASK;
   assign wrModeValue = {5'h00, wDataHeld[2:0]};

   // Area decode; upper address bits must be clear so only 4 Mbyte decodes.
   // Each area is one 1 Mbyte nibble plus its mirror, except area 0 in extension mode
   always @* begin
      hitArea0 = 1'b0;
      hitArea1 = 1'b0;
      if (accAddr[31:24] == 8'h00) begin
         case (opMode)
            `EWC_MODE_EXTEND: begin
               hitArea0 = (areaNibble == `EWC_AREA_NIBBLE_1);
               hitArea1 = (areaNibble == `EWC_AREA_NIBBLE_2) ||
                  (areaNibble == `EWC_AREA_NIBBLE_3);
            end
            `EWC_MODE_PROC: begin
               hitArea0 = (areaNibble == `EWC_AREA_NIBBLE_0) ||
                  (areaNibble == `EWC_AREA_NIBBLE_1);
               hitArea1 = (areaNibble == `EWC_AREA_NIBBLE_2) ||
                  (areaNibble == `EWC_AREA_NIBBLE_3);
            end
            default: begin
               // Single-chip and unused mode 3: no external area, settings unused
               hitArea0 = 1'b0;
               hitArea1 = 1'b0;
            end
         endcase
      end
   end

   // Field to count: 00 gives 4 down to 11 giving 1, never zero
   // A 3-bit count is enough; the subtraction never goes below one
   always @* begin
      next_waitCount = 3'h4;
      if (hitArea0)
         next_waitCount = 3'h4 -
            {1'b0, area0_wait_count_field};
      else
         next_waitCount = 3'h4 -
            {1'b0, area1_wait_count_field};
   end

   // Pin levels for a new cycle, all active low except the bus clock enable
   always @* begin
      next_readStrobe = accWrite;
      next_upperWrite = 1'b1;
      next_lowerWrite = 1'b1;
      next_upperEnable = 1'b1;
      next_lowerEnable = 1'b1;
      next_commonWrite = 1'b1;
      next_busClock = 1'b0;
      if (!strobeStyle) begin
         // Style 0: a write strobe per byte lane plus the bus clock
         next_upperWrite = !(accWrite & accByteEn[1]);
         next_lowerWrite = !(accWrite & accByteEn[0]);
         next_busClock = 1'b1;
      end else begin
         // Style 1: byte enables both ways and one write strobe; no bus
         // clock, so the far side must time its wait pin by itself
         next_upperEnable = !accByteEn[1];
         next_lowerEnable = !accByteEn[0];
         next_commonWrite = !accWrite;
      end
   end

   // Read data chosen ahead of the handshake; busy shows the sequencer
   always @* begin
      next_readData = 32'h00000000;
      next_readError = 1'b0;
      if (rdHitWait) begin
         next_readData = {24'h000000, external_wait_cycles_control};
      end else if (rdHitMode) begin
         next_readData = {23'h000000, state != ST_IDLE, modeControl};
      end else begin
         next_readError = 1'b1; // Unmapped: zero data, error response
      end
   end

   // Access sequencer. An external cycle is one address cycle followed by
   // the programmed waits, so 2 to 5 cycles without the pin
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         waitCount <= 3'h0;
         accDone <= 1'b0;
         accExternal <= 1'b0;
         area0_chip_select_b <= 1'b1;
         area1_chip_select_b <= 1'b1;
         read_strobe_b <= 1'b1;
         upper_byte_write_strobe_b <= 1'b1;
         lower_byte_write_strobe_b <= 1'b1;
         upper_byte_enable_b <= 1'b1;
         lower_byte_enable_b <= 1'b1;
         write_strobe_b <= 1'b1;
         busClockEnable <= 1'b0;
      end else if (clockEnable) begin
         accDone <= 1'b0;
         case (state)
            ST_IDLE: begin
               // accDone still high means the finished request is being
               // dropped; taking it again would start a second cycle
               if (accReq && !accDone) begin
                  if (anyHit) begin
                     state <= ST_WAIT;
                     waitCount <= next_waitCount;
                     accExternal <= 1'b1;
                     area0_chip_select_b <= !hitArea0;
                     area1_chip_select_b <= !hitArea1;
                     // Lane strobes follow the selected style
                     read_strobe_b <= next_readStrobe;
                     upper_byte_write_strobe_b <= next_upperWrite;
                     lower_byte_write_strobe_b <= next_lowerWrite;
                     upper_byte_enable_b <= next_upperEnable;
                     lower_byte_enable_b <= next_lowerEnable;
                     write_strobe_b <= next_commonWrite;
                     busClockEnable <= next_busClock;
                  end else begin
                     // Internal access: nothing inserted
                     accDone <= 1'b1;
                     accExternal <= 1'b0;
                  end
               end
            end
            ST_WAIT: begin
               // Programmed waits run out before the pin counts
               if (lastWait) begin
                  if (!wait_b)
                     state <= ST_EXTWAIT;
                  else
                     state <= ST_END;
               end else begin
                  waitCount <= waitCount - 3'h1;
               end
            end
            ST_EXTWAIT: begin
               // Prolong while the pin stays low; relies on
               if (wait_b)
                  state <= ST_END;
            end
            ST_END: begin
               // Release everything at once, with the done pulse
               state <= ST_IDLE;
               waitCount <= 3'h0;
               accDone <= 1'b1;
               area0_chip_select_b <= 1'b1;
               area1_chip_select_b <= 1'b1;
               read_strobe_b <= 1'b1;
               upper_byte_write_strobe_b <= 1'b1;
               lower_byte_write_strobe_b <= 1'b1;
               upper_byte_enable_b <= 1'b1;
               lower_byte_enable_b <= 1'b1;
               write_strobe_b <= 1'b1;
               busClockEnable <= 1'b0;
            end
            default: begin
               // Unused code: fall back to idle rather than hang
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // AXI write path: address and data taken in either order, then answer.
   // Each ready is high for one cycle at a time, so a channel is never
   // taken twice before the response has been accepted.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EWC_RESP_OKAY;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHeld <= 32'h00000000;
         wDataHeld <= 32'h00000000;
         wStrbHeld <= 4'h0;
         external_wait_cycles_control <= `EWC_WAIT_CTRL_RESET;
         modeControl <= `EWC_MODE_CTRL_RESET;
      end else if (clockEnable) begin
         s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddrHeld <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (awHeld && wHeld && !s_axi_bvalid) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `EWC_RESP_OKAY;
            if (wrHitWait) begin
               // A cleared lane strobe leaves the register as it was
               if (wStrbHeld[0])
                  external_wait_cycles_control <= wrWaitValue;
            end else if (wrHitMode) begin
               if (wStrbHeld[0])
                  modeControl <= wrModeValue;
            end else begin
               s_axi_bresp <= `EWC_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI read path: one read at a time, rvalid rises at the edge that takes the address
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `EWC_RESP_OKAY;
      end else if (clockEnable) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            // Data and response land together with rvalid
            s_axi_rdata <= next_readData;
            if (next_readError)
               s_axi_rresp <= `EWC_RESP_SLVERR;
            else
               s_axi_rresp <= `EWC_RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // ewc_wait_controller

// >>> sim/ewc_props.sv
// Checker for the external bus side of the wait controller.
// Assumes it is bound to ewc_wait_controller on its single clock.
`timescale 1ns/1ns
module ewc_props (
   input wire clock,
   input wire rst_b,
   input wire accDone,
   input wire accExternal,
   input wire [31:0] accAddr,
   input wire wait_b,
   input wire area0_chip_select_b,
   input wire area1_chip_select_b,
   input wire read_strobe_b
);
   // Any select low marks an external cycle in flight
   wire selOn = !area0_chip_select_b || !area1_chip_select_b;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Steps of an external cycle
   sequence s_start;
      $fell(area0_chip_select_b && area1_chip_select_b);
   endsequence
   sequence s_held;
      selOn && !wait_b && !accDone;
   endsequence
   a_one_select: assert property (area0_chip_select_b ||
      area1_chip_select_b)
      else $error("both chip selects low");
   a_min_wait: assert property (s_start |=> !accDone)
      else $error("external cycle ended with no wait");
   a_soft_limit: assert property (s_start ##1
      (wait_b && !accDone)[*4] |=> accDone)
      else $error("more than four programmed waits");
   a_pin_hold: assert property (s_held |=> !accDone)
      else $error("cycle ended while wait pin low");
   a_pin_end: assert property (s_held ##1 wait_b |-> ##[1:4] accDone)
      else $error("cycle did not end after wait pin rose");
   a_ext_only: assert property (accDone && !accExternal |-> !selOn)
      else $error("select low on an internal access");
   a_area0_addr: assert property ($fell(area0_chip_select_b) |->
      accAddr[31:21] == 11'h000)
      else $error("area 0 select outside its range");
   a_area1_addr: assert property ($fell(area1_chip_select_b) |->
      accAddr[31:21] == 11'h001)
      else $error("area 1 select outside its range");
   a_read_in_cycle: assert property (!read_strobe_b |-> selOn)
      else $error("read strobe outside an external cycle");
endmodule // ewc_props

bind ewc_wait_controller ewc_props i_props (.clock(clock), .rst_b(rst_b),
   .accDone(accDone), .accExternal(accExternal), .accAddr(accAddr),
   .wait_b(wait_b), .area0_chip_select_b(area0_chip_select_b),
   .area1_chip_select_b(area1_chip_select_b), .read_strobe_b(read_strobe_b));

// >>> sim/ewc_ext_mem.sv
// Model of the memories behind the two chip selects: drives the wait pin.
// Assumes synchronous pins; the pin has a pull-up and idles high.
`timescale 1ns/1ns
module ewc_ext_mem (
   input wire clock,
   input wire rst_b,
   input wire area0_chip_select_b,
   input wire area1_chip_select_b,
   input wire [3:0] holdCycles,
   output wire wait_b
);
   wire selOn = !area0_chip_select_b || !area1_chip_select_b;
   reg [3:0] elapsed;
   // Edges since a select went low; saturates so a long cycle never pulls the pin low again
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         elapsed <= 4'h0;
      else if (!selOn)
         elapsed <= 4'h0;
      else if (elapsed != 4'hf)
         elapsed <= elapsed + 4'h1;
   end
   // Low for the asked number of samples, high when no wait is needed
   assign wait_b = !(selOn && elapsed < holdCycles);
endmodule // ewc_ext_mem

// >>> sim/tb_external_bus_wait_controller.sv
// Bench for the wait controller: registers over AXI4-Lite, external
// cycles against the wait pin model. Assumes src/ on the include path.
`timescale 1ns/1ns
`include "ewc_defs.vh"
module tb_external_bus_wait_controller;
   reg clock = 0, rst_b = 0, accReq = 0, accWrite = 0;
   reg [31:0] accAddr = 0, s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   reg [3:0] holdCycles = 0;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   reg s_axi_arvalid = 0, s_axi_rready = 0;
   reg [8:0] seen;
   wire accDone, accExternal, wait_b, s_axi_awready, s_axi_wready;
   wire s_axi_bvalid, s_axi_arready, s_axi_rvalid, busClockEnable;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire area0_chip_select_b, area1_chip_select_b, read_strobe_b;
   wire upper_byte_write_strobe_b, lower_byte_write_strobe_b;
   wire upper_byte_enable_b, lower_byte_enable_b, write_strobe_b;
   integer bad_count = 0, num_checks = 0, cycles = 0, m, f;
   ewc_wait_controller i_dut (.clock(clock), .rst_b(rst_b), .clockEnable(1'b1),
      .accReq(accReq), .accAddr(accAddr), .accWrite(accWrite),
      .accByteEn(2'h3), .accDone(accDone), .accExternal(accExternal),
      .wait_b(wait_b), .area0_chip_select_b(area0_chip_select_b),
      .area1_chip_select_b(area1_chip_select_b), .read_strobe_b(read_strobe_b),
      .upper_byte_write_strobe_b(upper_byte_write_strobe_b),
      .lower_byte_write_strobe_b(lower_byte_write_strobe_b),
      .upper_byte_enable_b(upper_byte_enable_b),
      .lower_byte_enable_b(lower_byte_enable_b),
      .write_strobe_b(write_strobe_b), .busClockEnable(busClockEnable),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   ewc_ext_mem i_mem (.clock(clock), .rst_b(rst_b), .holdCycles(holdCycles),
      .area0_chip_select_b(area0_chip_select_b),
      .area1_chip_select_b(area1_chip_select_b), .wait_b(wait_b));
   // 25 MHz clock
   initial begin
      forever #20 clock = ~clock;
   end
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         give_verdict;
      end
   end
   task give_verdict;
      begin
         if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Cycles from request edge to done seen: waits, pin extension, two edges
   function integer cyc(input integer nw, input integer h);
      cyc = nw + 2 + (h >= nw ? h - nw + 1 : 0);
   endfunction
   // Write: address and data offered together, each released when taken
   task axw(input [31:0] a, input [31:0] d, input [1:0] er);
      reg done;
      begin
         @(posedge clock);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         done = 0;
         while (!done) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               done = 1;
               s_axi_bready <= 1'b0;
               chk(s_axi_bresp, er);
            end
         end
      end
   endtask
   task axr(input [31:0] a, input [31:0] ed, input [1:0] er);
      reg done;
      begin
         @(posedge clock);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         done = 0;
         while (!done) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               done = 1;
               s_axi_rready <= 1'b0;
               chk(s_axi_rdata, ed);
               chk(s_axi_rresp, er);
            end
         end
      end
   endtask
   // One core access; expN below zero skips the cycle count check
   task acc(input [31:0] a, input w, input [3:0] h, input integer expN,
      input [1:0] expSel);
      integer k;
      begin
         @(posedge clock);
         holdCycles <= h;
         accAddr <= a;
         accWrite <= w;
         accReq <= 1'b1;
         seen = 0;
         k = 0;
         while (!accDone) begin
            @(posedge clock);
            #1;
            k = k + 1;
            seen = seen | {busClockEnable, ~{write_strobe_b,
               upper_byte_write_strobe_b, lower_byte_write_strobe_b,
               upper_byte_enable_b, lower_byte_enable_b, read_strobe_b,
               area1_chip_select_b, area0_chip_select_b}};
         end
         @(posedge clock);
         accReq <= 1'b0;
         if (expN >= 0) chk(k, expN);
         chk(seen[1:0], expSel);
         chk(accExternal, expSel != 2'h0);
      end
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      axr(`EWC_WAIT_CTRL_ADDR, 32'h0, `EWC_RESP_OKAY);
      axr(`EWC_MODE_CTRL_ADDR, 32'h0, `EWC_RESP_OKAY);
      axr(32'h00800188, 32'h0, `EWC_RESP_SLVERR);
      axw(32'h00800188, 32'hff, `EWC_RESP_SLVERR);
      axw(`EWC_WAIT_CTRL_ADDR, 32'hff, `EWC_RESP_OKAY);
      axr(`EWC_WAIT_CTRL_ADDR, 32'h33, `EWC_RESP_OKAY);
      acc(32'h00200000, 1'b0, 4'h0, -1, 2'h0);
      for (m = 1; m < 3; m = m + 1) begin
         axw(`EWC_MODE_CTRL_ADDR, m == 1 ? 32'h1 : 32'h6, `EWC_RESP_OKAY);
         for (f = 0; f < 4; f = f + 1) begin
            axw(`EWC_WAIT_CTRL_ADDR, f * 16 + 3 - f, `EWC_RESP_OKAY);
            acc(m == 1 ? 32'h00100000 : 32'h000ffffe, f[0], f, cyc(4 - f, f),
               2'h1);
            acc(f[0] ? 32'h00300000 : 32'h002ffffe, f[1], 4'h0, cyc(1 + f, 0),
               2'h2);
         end
         acc(32'h00180000, 1'b0, 4'h5, cyc(1, 5), 2'h1);
         acc(32'h0, 1'b0, 4'h0, m == 1 ? -1 : cyc(1, 0),
            m == 1 ? 2'h0 : 2'h1);
         acc(32'h00400000, 1'b1, 4'h0, -1, 2'h0);
         acc(32'h00200000, 1'b1, 4'h0, cyc(4, 0), 2'h2);
         chk(seen[8:2], m == 1 ? 7'h58 : 7'h26);
         acc(32'h00200000, 1'b0, 4'h0, cyc(4, 0), 2'h2);
         chk(seen[8:2], m == 1 ? 7'h41 : 7'h07);
      end
      axw(`EWC_MODE_CTRL_ADDR, 32'h3, `EWC_RESP_OKAY);
      acc(32'h00200000, 1'b0, 4'h0, -1, 2'h0);
      give_verdict;
   end
endmodule // tb_external_bus_wait_controller
